// File: sfo_defs.svh
// Constants for the serial flag offset link, both ends
// Functional notes
// R1 - Load enable low shifts one bit per edge
// R2 - Empty offset LSB first, full offset MSB last
// R3 - SDR narrow pairing: 32 to 38 bits
// R4 - SDR other pairings: 30 to 36 bits
// R5 - DDR two bits shorter per depth
// R6 - Readback enable low shifts one bit out
// R7 - DDR memory write decode on write clock
// R8 - Flags valid only after full set loaded
// R9 - Each readback starts at first bit
// R10 - No enable keeps offsets and position
`ifndef SFO_DEFS_SVH
`define SFO_DEFS_SVH

// ****************************************
// Offset stream geometry
// ****************************************
`define SFO_MAX_BITS 38
`define SFO_HALF_BITS 19
`define SFO_LEN_BASE 6'h1E
`define SFO_LEN_NARROW 6'h02
`define SFO_LEN_DDR_CUT 6'h02
`define SFO_LEN_STEP 6'h02
`define SFO_LEN_ONE 6'h01

// ****************************************
// Controller register map (byte addresses)
// ****************************************
`define SFO_ADDR_CTRL 12'h000
`define SFO_ADDR_CFG 12'h004
`define SFO_ADDR_LOAD_LO 12'h008
`define SFO_ADDR_LOAD_HI 12'h00C
`define SFO_ADDR_READ_LO 12'h010
`define SFO_ADDR_READ_HI 12'h014
`define SFO_ADDR_STATUS 12'h018

// ****************************************
// Controller register fields
// ****************************************
`define SFO_CTRL_START_LOAD 0
`define SFO_CTRL_START_READ 1
`define SFO_CTRL_WEN 2
`define SFO_CTRL_REN 3
`define SFO_CTRL_WRATE 4
`define SFO_CTRL_RRATE 5
`define SFO_CFG_NARROW 2
`define SFO_STAT_BUSY 0
`define SFO_STAT_DONE 1
`define SFO_HI_BITS 6

// ****************************************
// Serial clock divider phases
// ****************************************
`define SFO_PH_FALL 2'h3
`define SFO_PH_RISE 2'h1
`define SFO_PH_HIGH 2'h2

`endif

// File: sfo_pkg.sv
// Types and shared decoding for the serial flag offset link
`default_nettype none
`include "sfo_defs.svh"

package sfo_pkg;

	typedef enum logic [1:0] {
		SFO_IDLE = 2'h0,
		SFO_LOAD = 2'h1,
		SFO_READ = 2'h2
	} sfo_ctl_state_t;

	typedef logic [`SFO_MAX_BITS-1:0] sfo_stream_t;

	// Stream length from depth option, width pairing and rate
	function automatic logic [5:0] sfo_bit_len(input logic [1:0] depth, input logic narrow, input logic ddr);
		logic [5:0] len;
		len = `SFO_LEN_BASE + ({4'h0, depth} * `SFO_LEN_STEP);
		// R3 narrow pair adds two
		if (narrow) begin
			len = len + `SFO_LEN_NARROW;
		end
		// R5 DDR two shorter
		if (ddr) begin
			len = len - `SFO_LEN_DDR_CUT;
		end
		// R4 other pairings base
		return len;
	endfunction

endpackage

`default_nettype wire

// File: sfo_link_if.sv
// Link between offset controller and FIFO offset port
`timescale 1ns/100ps
`default_nettype none

interface sfo_link_if;
	logic sclk;
	logic wen_n;
	logic ren_n;
	logic serial_load_enable_n;
	logic serial_readback_enable_n;
	logic write_port_rate_select;
	logic read_port_rate_select;
	logic serial_in;
	logic serial_out;

	modport ctl (
		output sclk,
		output wen_n,
		output ren_n,
		output serial_load_enable_n,
		output serial_readback_enable_n,
		output write_port_rate_select,
		output read_port_rate_select,
		output serial_in,
		input serial_out
	);

	modport dev (
		input sclk,
		input wen_n,
		input ren_n,
		input serial_load_enable_n,
		input serial_readback_enable_n,
		input write_port_rate_select,
		input read_port_rate_select,
		input serial_in,
		output serial_out
	);
endinterface

`default_nettype wire

// File: sfo_offset_dev.sv
// FIFO end: offset shift register on the serial clock, DDR write decode
`timescale 1ns/100ps
`default_nettype none
`include "sfo_defs.svh"

module sfo_offset_dev
	import sfo_pkg::*;
(
	sfo_link_if.dev link,
	input wire logic wclk,
	input wire logic presetn,
	input wire logic [1:0] depth_sel,
	input wire logic narrow_pair,
	output logic [`SFO_HALF_BITS-1:0] empty_offset,
	output logic [`SFO_HALF_BITS-1:0] full_offset,
	output logic offsets_valid,
	output logic mem_ddr_write
);

	// ****************************************
	// Configuration straps into serial domain
	// ****************************************
	logic [2:0] cfg_s1_q;
	logic [2:0] cfg_s2_q;

	// Straps are static but asynchronous to the link clock
	always_ff @(posedge link.sclk or negedge presetn) begin
		if (!presetn) begin
			cfg_s1_q <= 3'h0;
			cfg_s2_q <= 3'h0;
		end else begin
			cfg_s1_q <= {narrow_pair, depth_sel};
			cfg_s2_q <= cfg_s1_q;
		end
	end

	// ****************************************
	// Mode decode
	// ****************************************
	logic ddr_mode;
	logic [5:0] len;
	logic [5:0] last_pos;
	logic [5:0] half;
	logic load_op;
	logic read_op;

	// Either port at double rate shortens the stream
	assign ddr_mode = link.write_port_rate_select | link.read_port_rate_select;
	// R3 R4 R5 length select
	assign len = sfo_bit_len(cfg_s2_q[1:0], cfg_s2_q[2], ddr_mode);
	assign last_pos = len - `SFO_LEN_ONE;
	assign half = {1'b0, len[5:1]};

	// R1 load decode
	assign load_op = link.wen_n & link.ren_n & ~link.serial_load_enable_n & link.serial_readback_enable_n;
	// R6 readback decode
	assign read_op = link.wen_n & link.ren_n & link.serial_load_enable_n & ~link.serial_readback_enable_n;

	// ****************************************
	// Offset load
	// ****************************************
	sfo_stream_t off_q;
	logic [5:0] ld_pos_q;
	logic set_done_q;

	// R1 one bit per rising edge
	always_ff @(posedge link.sclk or negedge presetn) begin
		if (!presetn) begin
			off_q <= '0;
		end else if (load_op) begin
			// R2 bit zero is empty LSB
			off_q[ld_pos_q] <= link.serial_in;
		end
	end

	// R10 position held without an enable
	always_ff @(posedge link.sclk or negedge presetn) begin
		if (!presetn) begin
			ld_pos_q <= 6'h00;
		end else if (load_op) begin
			if (ld_pos_q >= last_pos) begin
				ld_pos_q <= 6'h00;
			end else begin
				ld_pos_q <= ld_pos_q + `SFO_LEN_ONE;
			end
		end
	end

	always_ff @(posedge link.sclk or negedge presetn) begin
		if (!presetn) begin
			set_done_q <= 1'b0;
		end else begin
			set_done_q <= load_op && (ld_pos_q >= last_pos);
		end
	end

	// ****************************************
	// Flag offsets and validity
	// ****************************************
	function automatic logic [`SFO_HALF_BITS-1:0] sfo_field(input sfo_stream_t s, input logic [5:0] base,
		input logic [5:0] n);
		logic [`SFO_HALF_BITS-1:0] f;
		f = '0;
		for (int i = 0; i < `SFO_HALF_BITS; i++) begin
			if (6'(i) < n) begin
				f[i] = s[6'(i) + base];
			end
		end
		return f;
	endfunction

	// R8 valid only after full set
	always_ff @(posedge link.sclk or negedge presetn) begin
		if (!presetn) begin
			offsets_valid <= 1'b0;
		end else if (set_done_q) begin
			offsets_valid <= 1'b1;
		end else if (load_op && ld_pos_q == 6'h00) begin
			offsets_valid <= 1'b0;
		end
	end

	// R2 empty low half, full high half
	always_ff @(posedge link.sclk or negedge presetn) begin
		if (!presetn) begin
			empty_offset <= '0;
			full_offset <= '0;
		end else if (set_done_q) begin
			empty_offset <= sfo_field(off_q, 6'h00, half);
			full_offset <= sfo_field(off_q, half, half);
		end
	end

	// ****************************************
	// Offset readback
	// ****************************************
	logic rd_active_q;
	logic [5:0] rd_pos_q;
	logic [5:0] rd_pos;

	// R9 restart at first bit each readback
	assign rd_pos = rd_active_q ? rd_pos_q : 6'h00;

	always_ff @(posedge link.sclk or negedge presetn) begin
		if (!presetn) begin
			rd_active_q <= 1'b0;
		end else begin
			rd_active_q <= read_op;
		end
	end

	// R6 same order and length as load
	always_ff @(posedge link.sclk or negedge presetn) begin
		if (!presetn) begin
			rd_pos_q <= 6'h00;
		end else if (read_op) begin
			if (rd_pos >= last_pos) begin
				rd_pos_q <= 6'h00;
			end else begin
				rd_pos_q <= rd_pos + `SFO_LEN_ONE;
			end
		end
	end

	always_ff @(posedge link.sclk or negedge presetn) begin
		if (!presetn) begin
			link.serial_out <= 1'b0;
		end else if (read_op) begin
			link.serial_out <= off_q[rd_pos];
		end
	end

	// ****************************************
	// DDR memory write decode, write clock
	// ****************************************
	logic [3:0] wsync1_q;
	logic [3:0] wsync2_q;

	// Enables come from another clock; two stages before decode
	always_ff @(posedge wclk or negedge presetn) begin
		if (!presetn) begin
			wsync1_q <= 4'hF;
			wsync2_q <= 4'hF;
		end else begin
			wsync1_q <= {link.write_port_rate_select, link.read_port_rate_select, link.wen_n, link.ren_n};
			wsync2_q <= wsync1_q;
		end
	end

	// R7 both rates high, write low, read high
	always_ff @(posedge wclk or negedge presetn) begin
		if (!presetn) begin
			mem_ddr_write <= 1'b0;
		end else begin
			mem_ddr_write <= wsync2_q[3] & wsync2_q[2] & ~wsync2_q[1] & wsync2_q[0];
		end
	end

endmodule

`default_nettype wire

// File: sfo_offset_ctl.sv
// Controller end: APB registers driving the serial offset link
`timescale 1ns/100ps
`default_nettype none
`include "sfo_defs.svh"

module sfo_offset_ctl
	import sfo_pkg::*;
(
	sfo_link_if.ctl link,
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);

	// ****************************************
	// Registers and APB slave
	// ****************************************
	logic [5:0] ctrl_q;
	logic [2:0] cfg_q;
	sfo_stream_t load_q;
	sfo_stream_t read_q;
	logic done_q;
	sfo_ctl_state_t state_q;
	logic wr_acc;
	logic busy;

	assign busy = (state_q != SFO_IDLE);
	assign wr_acc = psel & penable & pready & pwrite;

	// One wait state: pready rises on the second access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end else begin
			pready <= psel & penable & ~pready;
			pslverr <= 1'b0;
			prdata <= 32'h0;
			if (psel & penable & ~pready) begin
				unique case (paddr)
					`SFO_ADDR_CTRL: prdata <= {26'h0, ctrl_q};
					`SFO_ADDR_CFG: prdata <= {29'h0, cfg_q};
					`SFO_ADDR_LOAD_LO: prdata <= load_q[31:0];
					`SFO_ADDR_LOAD_HI: prdata <= {26'h0, load_q[`SFO_MAX_BITS-1:32]};
					`SFO_ADDR_READ_LO: prdata <= read_q[31:0];
					`SFO_ADDR_READ_HI: prdata <= {26'h0, read_q[`SFO_MAX_BITS-1:32]};
					`SFO_ADDR_STATUS: prdata <= {30'h0, done_q, busy};
					default: pslverr <= 1'b1;
				endcase
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_q <= 3'h0;
			load_q <= '0;
		end else if (wr_acc) begin
			if (paddr == `SFO_ADDR_CFG) begin
				cfg_q <= pwdata[2:0];
			end
			if (paddr == `SFO_ADDR_LOAD_LO) begin
				load_q[31:0] <= pwdata;
			end
			if (paddr == `SFO_ADDR_LOAD_HI) begin
				load_q[`SFO_MAX_BITS-1:32] <= pwdata[`SFO_HI_BITS-1:0];
			end
		end
	end

	// Start bits self-clear when the transfer is taken
	logic take_start;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= 6'h00;
		end else if (wr_acc && paddr == `SFO_ADDR_CTRL) begin
			ctrl_q <= pwdata[5:0];
		end else if (take_start) begin
			ctrl_q[1:0] <= 2'h0;
		end
	end

	// ****************************************
	// Serial clock divider
	// ****************************************
	logic [1:0] ph_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ph_q <= 2'h0;
			link.sclk <= 1'b0;
		end else begin
			ph_q <= ph_q + 2'h1;
			link.sclk <= (ph_q == `SFO_PH_RISE) || (ph_q == `SFO_PH_HIGH);
		end
	end

	// ****************************************
	// Readback synchroniser
	// ****************************************
	logic so_s1_q;
	logic so_s2_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			so_s1_q <= 1'b0;
			so_s2_q <= 1'b0;
		end else begin
			so_s1_q <= link.serial_out;
			so_s2_q <= so_s1_q;
		end
	end

	// ****************************************
	// Transfer sequencer
	// ****************************************
	logic [5:0] len;
	logic [5:0] cnt_q;
	logic [5:0] cap_q;
	logic rose_q;
	logic fall_edge;
	logic mem_req;

	// R3 R4 R5 length select
	assign len = sfo_bit_len(cfg_q[1:0], cfg_q[`SFO_CFG_NARROW], ctrl_q[`SFO_CTRL_WRATE] | ctrl_q[`SFO_CTRL_RRATE]);
	assign fall_edge = (ph_q == `SFO_PH_FALL);
	assign mem_req = ctrl_q[`SFO_CTRL_WEN] | ctrl_q[`SFO_CTRL_REN];
	// Serial work is refused while a memory access is requested
	assign take_start = fall_edge && state_q == SFO_IDLE && !mem_req && ctrl_q[1:0] != 2'h0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= SFO_IDLE;
			cnt_q <= 6'h00;
			link.serial_load_enable_n <= 1'b1;
			link.serial_readback_enable_n <= 1'b1;
			link.serial_in <= 1'b0;
		end else begin
			unique case (state_q)
				SFO_IDLE: begin
					// R1 change only away from rising edge
					if (take_start && ctrl_q[`SFO_CTRL_START_LOAD]) begin
						state_q <= SFO_LOAD;
						link.serial_load_enable_n <= 1'b0;
						// R2 empty LSB first
						link.serial_in <= load_q[0];
						cnt_q <= 6'h00;
					end else if (take_start) begin
						state_q <= SFO_READ;
						// R6 readback enable low
						link.serial_readback_enable_n <= 1'b0;
						cnt_q <= 6'h00;
					end
				end
				SFO_LOAD: begin
					if (fall_edge) begin
						if (cnt_q == len - `SFO_LEN_ONE) begin
							state_q <= SFO_IDLE;
							link.serial_load_enable_n <= 1'b1;
						end else begin
							cnt_q <= cnt_q + `SFO_LEN_ONE;
							link.serial_in <= load_q[cnt_q + `SFO_LEN_ONE];
						end
					end
				end
				SFO_READ: begin
					if (fall_edge && !link.serial_readback_enable_n) begin
						if (cnt_q == len - `SFO_LEN_ONE) begin
							link.serial_readback_enable_n <= 1'b1;
						end else begin
							cnt_q <= cnt_q + `SFO_LEN_ONE;
						end
					end
					if (ph_q == `SFO_PH_RISE && rose_q && cap_q == len - `SFO_LEN_ONE) begin
						state_q <= SFO_IDLE;
					end
				end
				default: state_q <= SFO_IDLE;
			endcase
		end
	end

	// Captured bit k lags its rising edge by one serial period
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rose_q <= 1'b0;
			cap_q <= 6'h00;
			read_q <= '0;
		end else if (state_q != SFO_READ) begin
			rose_q <= 1'b0;
			cap_q <= 6'h00;
		end else if (ph_q == `SFO_PH_RISE) begin
			rose_q <= 1'b1;
			if (rose_q) begin
				// R2 R9 first bit lands at index zero
				read_q[cap_q] <= so_s2_q;
				cap_q <= cap_q + `SFO_LEN_ONE;
			end
		end
	end

	// Set wins over the clear from a new start
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done_q <= 1'b0;
		end else if (busy && state_q != SFO_IDLE && ((state_q == SFO_LOAD && fall_edge && cnt_q == len - `SFO_LEN_ONE)
			|| (state_q == SFO_READ && ph_q == `SFO_PH_RISE && rose_q && cap_q == len - `SFO_LEN_ONE))) begin
			done_q <= 1'b1;
		end else if (take_start) begin
			done_q <= 1'b0;
		end
	end

	// ****************************************
	// FIFO enables and rate selects
	// ****************************************
	// R7 memory write levels from register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			link.wen_n <= 1'b1;
			link.ren_n <= 1'b1;
			link.write_port_rate_select <= 1'b0;
			link.read_port_rate_select <= 1'b0;
		end else begin
			link.wen_n <= busy | ~ctrl_q[`SFO_CTRL_WEN];
			link.ren_n <= busy | ~ctrl_q[`SFO_CTRL_REN];
			link.write_port_rate_select <= ctrl_q[`SFO_CTRL_WRATE];
			link.read_port_rate_select <= ctrl_q[`SFO_CTRL_RRATE];
		end
	end

endmodule

`default_nettype wire

// File: sfo_link_sva.sv
// Checker for the serial offset link between controller and FIFO end
`timescale 1ns/100ps
`default_nettype none

module sfo_link_sva (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic sclk,
	input wire logic wen_n,
	input wire logic ren_n,
	input wire logic serial_load_enable_n,
	input wire logic serial_readback_enable_n,
	input wire logic serial_in,
	input wire logic serial_out
);
	logic [5:0] load_bits_q;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// ****************************************
	// Sequences
	// ****************************************
	sequence sclk_high_phase;
		sclk [*2] ##1 !sclk;
	endsequence

	sequence fifo_quiet;
		wen_n && ren_n;
	endsequence

	// Counts serial rises inside one load frame; a split frame would read short
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			load_bits_q <= 6'h00;
		end else if (serial_load_enable_n) begin
			load_bits_q <= 6'h00;
		end else if ($rose(sclk)) begin
			load_bits_q <= load_bits_q + 6'h01;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	sclk_high_len_a: assert property ($rose(sclk) |-> sclk_high_phase)
		else $error("serial clock high phase wrong");
	load_en_edge_a: assert property ($changed(serial_load_enable_n) |-> $fell(sclk))
		else $error("load enable moved off falling serial edge");
	rb_en_edge_a: assert property ($changed(serial_readback_enable_n) |-> $fell(sclk))
		else $error("readback enable moved off falling serial edge");
	sin_edge_a: assert property ($changed(serial_in) |-> $fell(sclk))
		else $error("serial input moved off falling serial edge");
	load_quiet_a: assert property (!serial_load_enable_n |-> fifo_quiet and serial_readback_enable_n)
		else $error("fifo enable active during load");
	rb_quiet_a: assert property (!serial_readback_enable_n |-> fifo_quiet and serial_load_enable_n)
		else $error("fifo enable active during readback");
	sout_edge_a: assert property ($changed(serial_out) |-> $rose(sclk))
		else $error("serial output moved off rising serial edge");
	load_len_a: assert property ($rose(serial_load_enable_n) |-> load_bits_q inside {[28:38]} && !load_bits_q[0])
		else $error("load frame length out of range");
endmodule

`default_nettype wire

// File: tb.sv
// Testbench: controller and FIFO end joined over the serial offset link
`timescale 1ns/100ps
`default_nettype none
`include "sfo_defs.svh"

module tb;
	logic pclk, wclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [1:0] depth_sel;
	logic narrow_pair, offsets_valid, mem_ddr_write;
	logic [18:0] empty_offset, full_offset;
	int miscompares, checks;

	sfo_link_if link();

	sfo_offset_ctl i_sfo_offset_ctl(.link(link), .pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));
	sfo_offset_dev i_sfo_offset_dev(.link(link), .wclk(wclk), .presetn(presetn), .depth_sel(depth_sel),
		.narrow_pair(narrow_pair), .empty_offset(empty_offset), .full_offset(full_offset),
		.offsets_valid(offsets_valid), .mem_ddr_write(mem_ddr_write));
	sfo_link_sva i_sfo_link_sva(.pclk(pclk), .presetn(presetn), .sclk(link.sclk), .wen_n(link.wen_n),
		.ren_n(link.ren_n), .serial_load_enable_n(link.serial_load_enable_n),
		.serial_readback_enable_n(link.serial_readback_enable_n), .serial_in(link.serial_in),
		.serial_out(link.serial_out));

	// ****************************************
	// Clocks and common tasks
	// ****************************************
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	// Write clock unrelated in phase to pclk
	initial begin
		wclk = 1'b0;
		#7;
		forever #32 wclk = ~wclk;
	end

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic complete_run;
		$display("checks=%0d miscompares=%0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
		output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask

	task automatic rd(input logic [11:0] a, output logic [31:0] r);
		logic e;
		apb(1'b0, a, 32'h0000_0000, r, e);
	endtask

	// Starts a link session and polls until done; busy must be clear by then
	task automatic run(input logic [5:0] ctrl);
		logic [31:0] s;
		wr(`SFO_ADDR_CTRL, {26'h0, ctrl});
		// Wait for the start to be taken, else a stale done from the last session passes
		do begin
			rd(`SFO_ADDR_CTRL, s);
		end while (s[1:0] !== 2'h0);
		do begin
			rd(`SFO_ADDR_STATUS, s);
		end while (s[1] !== 1'b1);
		check(64'(s[1:0]), 64'h2);
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic test_reset;
		logic [31:0] r;
		logic e;
		rd(`SFO_ADDR_CTRL, r);
		check(64'(r), 64'h0);
		check(64'(offsets_valid), 64'h0);
		apb(1'b0, 12'h01C, 32'h0000_0000, r, e);
		check({31'h0, e, r}, 64'h1_0000_0000);
		$display("test reset done");
	endtask

	// Every depth, width pairing and rate: load, read back twice, check offsets
	task automatic test_modes;
		logic [63:0] stream, mask, hmask;
		logic [31:0] lo, hi;
		logic [5:0] rate;
		int len, half;
		for (int i = 0; i < 16; i++) begin
			len = 30 + 2 * (i % 4) + (i[2] ? 2 : 0) - (i[3] ? 2 : 0);
			half = len / 2;
			mask = (64'h1 << len) - 64'h1;
			hmask = (64'h1 << half) - 64'h1;
			stream = {26'h0, 6'(i) ^ 6'h2A, 32'h9E37_79B9 * (i + 1)} & mask;
			rate = i[3] ? 6'h30 : 6'h00;
			depth_sel <= 2'(i);
			narrow_pair <= i[2];
			wr(`SFO_ADDR_CFG, {29'h0, i[2], 2'(i)});
			// Readback only to give the strap synchronisers serial edges
			run(rate | 6'h02);
			wr(`SFO_ADDR_LOAD_LO, stream[31:0]);
			wr(`SFO_ADDR_LOAD_HI, {26'h0, stream[37:32]});
			run(rate | 6'h01);
			for (int k = 0; k < 2; k++) begin
				run(rate | 6'h02);
				rd(`SFO_ADDR_READ_LO, lo);
				rd(`SFO_ADDR_READ_HI, hi);
				check({26'h0, hi[5:0], lo} & mask, stream);
			end
			check(64'(offsets_valid), 64'h1);
			check(64'(empty_offset), stream & hmask);
			check(64'(full_offset), (stream >> half) & hmask);
		end
		$display("test modes done");
	endtask

	task automatic test_ddr_write;
		logic [5:0] ctrl [3];
		logic exp [3];
		ctrl = '{6'h34, 6'h04, 6'h3C};
		exp = '{1'b1, 1'b0, 1'b0};
		for (int i = 0; i < 3; i++) begin
			wr(`SFO_ADDR_CTRL, {26'h0, ctrl[i]});
			repeat (6) @(posedge wclk);
			check(64'(mem_ddr_write), 64'(exp[i]));
		end
		wr(`SFO_ADDR_CTRL, 32'h0000_0000);
		$display("test ddr write done");
	endtask

	// Cut frames: straps make the device two bits longer than the controller
	task automatic test_cut;
		logic [31:0] s1, s2, s3, lo;
		s1 = 32'hC3A5_5A3C;
		s2 = 32'h1234_5678;
		s3 = 32'h9ABC_DEF0;
		depth_sel <= 2'h0;
		narrow_pair <= 1'b1;
		wr(`SFO_ADDR_CFG, 32'h0000_0004);
		wr(`SFO_ADDR_LOAD_LO, s1);
		run(6'h01);
		wr(`SFO_ADDR_CFG, 32'h0000_0000);
		run(6'h02);
		rd(`SFO_ADDR_READ_LO, lo);
		check(64'(lo[29:0]), 64'(s1[29:0]));
		wr(`SFO_ADDR_CFG, 32'h0000_0004);
		run(6'h02);
		rd(`SFO_ADDR_READ_LO, lo);
		check(64'(lo), 64'(s1));
		check(64'(empty_offset), 64'(s1[15:0]));
		check(64'(full_offset), 64'(s1[31:16]));
		wr(`SFO_ADDR_LOAD_LO, s2);
		wr(`SFO_ADDR_CFG, 32'h0000_0000);
		run(6'h01);
		check(64'(offsets_valid), 64'h0);
		check(64'(full_offset), 64'(s1[31:16]));
		wr(`SFO_ADDR_LOAD_LO, s3);
		wr(`SFO_ADDR_CFG, 32'h0000_0004);
		run(6'h01);
		run(6'h02);
		rd(`SFO_ADDR_READ_LO, lo);
		check(64'(lo), 64'({s3[1:0], s3[31:2]}));
		check(64'(offsets_valid), 64'h1);
		check(64'(empty_offset), 64'(s2[15:0]));
		check(64'(full_offset), 64'({s3[1:0], s2[29:16]}));
		$display("test cut done");
	endtask

	// ****************************************
	// Main sequence and watchdog
	// ****************************************
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		depth_sel = 2'h0;
		narrow_pair = 1'b0;
		miscompares = 0;
		checks = 0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		test_reset();
		test_modes();
		test_ddr_write();
		test_cut();
		complete_run();
	end

	// Whole run needs under 2 ms; this cuts a hang well after that
	initial begin
		#6000000;
		miscompares++;
		complete_run();
	end
endmodule

`default_nettype wire
